// ===== iadc_pkg.sv
// Constants, types and register map of the incremental converter sequencer
// What this block does
// RQ1 - Setting either start bit begins a new conversion
// RQ2 - A conversion is N elementary conversions then one final quantization step
// RQ3 - Each elementary conversion lasts exactly OSR+1 oversampling periods
// RQ4 - The final code is the mean of all elementary conversion results
// RQ5 - Offset polarity alternates on successive elementary conversions
// RQ6 - Extra cycles before and after the elementary conversions initialise and close it
// RQ7 - Bandgap state held high, held low, toggled per conversion or every second
// RQ8 - Oversampling clock divides the 4 MHz oscillator: 62.5, 125, 250, 500 kHz
// RQ9 - OSR is two to the power three plus the 3-bit field, 8 to 1024
// RQ10 - Elementary count is two to the power of the 2-bit field, 1 to 8
// RQ11 - Host should configure at least two elementary conversions
// RQ12 - Resolution equals twice log2 of OSR plus log2 of the count
// RQ13 - One bit selects first stage gain of one or ten
// RQ14 - Second stage has 2-bit gain and 4-bit offset selections
// RQ15 - Third stage has 7-bit gain and 7-bit offset selections
// RQ16 - A 4-bit enable word enables converter and each amplifier stage
// RQ17 - The result register is 16 bits; higher resolution is truncated
// RQ18 - Total time is N times OSR+1 plus one oversampling period
// RQ19 - At the end: store result, clear start bits, raise done
// RQ20 - A start during a conversion restarts it with current configuration
package iadc_pkg;
    // Word offsets on the bus (byte addresses)
    localparam logic [7:0] IADC_ADR_SETUP_A = 8'h00;
    localparam logic [7:0] IADC_ADR_ENABLE = 8'h04;
    localparam logic [7:0] IADC_ADR_CLK_STAGE2 = 8'h08;
    localparam logic [7:0] IADC_ADR_STAGE3_GAIN = 8'h0C;
    localparam logic [7:0] IADC_ADR_STAGE3_OFFSET = 8'h10;
    localparam logic [7:0] IADC_ADR_BANDGAP = 8'h14;
    localparam logic [7:0] IADC_ADR_RESULT = 8'h18;
    localparam logic [7:0] IADC_ADR_STATUS = 8'h1C;
    // Field positions
    localparam int IADC_START_BIT = 0;
    localparam int IADC_ALT_START_BIT = 1;
    localparam int IADC_OSR_LSB = 2;
    localparam int IADC_NELC_LSB = 5;
    localparam int IADC_RATE_LSB = 6;
    localparam int IADC_S2_GAIN_LSB = 4;
    localparam int IADC_S1_GAIN_BIT = 7;
    localparam int IADC_DONE_BIT = 0;
    localparam int IADC_BUSY_BIT = 1;
    localparam int IADC_RES_LSB = 8;
    // Reset values
    localparam logic [7:0] IADC_SETUP_A_RST = 8'h00;
    localparam logic [3:0] IADC_ENABLE_RST = 4'h0;
    localparam logic [7:0] IADC_CLK_STAGE2_RST = 8'h00;
    localparam logic [7:0] IADC_BYTE_RST = 8'h00;
    localparam logic [15:0] IADC_RESULT_RST = 16'h0000;
    // Oscillator edges per oversampling period at the slowest rate
    localparam logic [6:0] IADC_DIV_BASE = 7'h40;
    // OSR exponent offset
    localparam logic [4:0] IADC_OSR_EXP_BASE = 5'h03;
    localparam logic [4:0] IADC_RESULT_BITS = 5'h10;
    // Bandgap modes
    localparam logic [1:0] IADC_BG_LOW = 2'h0;
    localparam logic [1:0] IADC_BG_HIGH = 2'h1;
    localparam logic [1:0] IADC_BG_TOGGLE = 2'h2;
    localparam logic [1:0] IADC_BG_HALF = 2'h3;

    typedef enum logic [3:0] {
        IADC_IDLE = 4'b0001,
        IADC_INIT = 4'b0010,
        IADC_ELEM = 4'b0100,
        IADC_FINAL = 4'b1000
    } iadc_state_t;

    // Configuration latched at start
    typedef struct packed {
        logic [2:0] osr_sel;
        logic [1:0] nelc_sel;
        logic [1:0] bg_mode;
    } iadc_cfg_t;
endpackage : iadc_pkg

// ===== iadc_osc_div.sv
// Divider from the oscillator to the oversampling tick
`timescale 1ns/1ns
`default_nettype none
module iadc_osc_div (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Oscillator and rate select
    input wire logic osc_in,
    input wire logic [1:0] clk_sel,
    // One-cycle tick per oversampling period
    output logic tick
);
    import iadc_pkg::*;
    logic osc_reg, osc_next;
    logic [6:0] cnt_reg, cnt_next;
    logic tick_reg, tick_next;
    logic [6:0] period;

    always_comb begin
        period = IADC_DIV_BASE >> clk_sel; // RQ8
        osc_next = osc_in;
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (osc_in && !osc_reg) begin
            if (cnt_reg >= period - 7'h01) begin
                cnt_next = 7'h00;
                tick_next = 1'b1; // RQ8
            end else begin
                cnt_next = cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            osc_reg <= 1'b0;
            cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else begin
            osc_reg <= osc_next;
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

    property p_tick_on_wrap;
        @(posedge clock) disable iff (!resetn)
        (osc_in && !osc_reg && cnt_reg == period - 7'h01 && $stable(clk_sel))
            |=> tick && cnt_reg == 7'h00;
    endproperty
    a_tick_on_wrap: assert property (p_tick_on_wrap) else $error("tick missed"); // RQ8
endmodule : iadc_osc_div
`default_nettype wire

// ===== iadc_integrator.sv
// Double integrator of the modulator bit stream
`timescale 1ns/1ns
`default_nettype none
module iadc_integrator #(
    parameter int ACC_W = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control
    input wire logic clear,
    input wire logic sample,
    input wire logic bit_in,
    // Second integrator value
    output logic [ACC_W-1:0] acc
);
    logic [ACC_W-1:0] acc1_reg, acc1_next, acc2_reg, acc2_next;

    always_comb begin
        acc1_next = acc1_reg;
        acc2_next = acc2_reg;
        if (clear) begin
            acc1_next = '0;
            acc2_next = '0;
        end else if (sample) begin
            acc1_next = acc1_reg + ACC_W'(bit_in);
            acc2_next = acc2_reg + acc1_next;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc1_reg <= '0;
            acc2_reg <= '0;
        end else begin
            acc1_reg <= acc1_next;
            acc2_reg <= acc2_next;
        end
    end

    assign acc = acc2_reg;

    property p_clear;
        @(posedge clock) disable iff (!resetn)
        clear |=> acc == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("integrator not cleared"); // RQ3
endmodule : iadc_integrator
`default_nettype wire

// ===== iadc_sequencer.sv
// Incremental converter sequencer with Wishbone registers and stage controls
`timescale 1ns/1ns
`default_nettype none
module iadc_sequencer #(
    parameter int ACC_W = 20,
    parameter int SUM_W = 23
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Oscillator and modulator
    input wire logic osc_in,
    input wire logic modulator_bit,
    // Analog controls
    output logic chop_polarity,
    output logic bandgap_state,
    output logic integrate_active,
    output logic [3:0] stage_enable,
    output logic stage1_gain_select,
    output logic [1:0] stage2_gain_select,
    output logic [3:0] stage2_offset_select,
    output logic [6:0] stage3_gain_select,
    output logic [6:0] stage3_offset_select
);
    import iadc_pkg::*;

    function automatic logic [4:0] iadc_res_bits(input logic [2:0] osr, input logic [1:0] nelc);
        iadc_res_bits = 5'((IADC_OSR_EXP_BASE + 5'(osr)) << 1) + 5'(nelc); // RQ12
    endfunction : iadc_res_bits

    // The sum carries log2(N) fraction bits of the mean, so aligning it is the mean
    function automatic logic [15:0] iadc_align(input logic [SUM_W-1:0] s, input logic [4:0] n);
        logic [SUM_W+15:0] w;
        w = {16'h0000, s} << 16;
        w = w >> n;
        if (w[SUM_W+15:16] != '0) begin
            iadc_align = 16'hFFFF; // RQ17
        end else begin
            iadc_align = w[15:0];
        end
    endfunction : iadc_align

    // Bus and register state
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [7:0] setup_a_reg, setup_a_next;
    logic [3:0] enable_reg, enable_next;
    logic [7:0] clk_s2_reg, clk_s2_next;
    logic [7:0] s3_gain_reg, s3_gain_next;
    logic [6:0] s3_off_reg, s3_off_next;
    logic [1:0] bg_reg, bg_next;
    logic [15:0] result_reg, result_next;
    logic done_reg, done_next;
    // Sequencer state
    iadc_state_t state_reg, state_next;
    iadc_cfg_t cfg_reg, cfg_next;
    logic [10:0] tick_cnt_reg, tick_cnt_next;
    logic [2:0] elem_cnt_reg, elem_cnt_next;
    logic [SUM_W-1:0] sum_reg, sum_next;
    logic harvest_reg, harvest_next;
    logic chop_reg, chop_next;
    logic bgs_reg, bgs_next;
    logic integ_reg, integ_next;

    logic tick;
    logic [ACC_W-1:0] acc;
    logic bus_req, wr_en, start_wr, elem_end;
    logic [10:0] osr_val;
    logic [2:0] last_elem;

    iadc_osc_div u_div (
        .clock(clock),
        .resetn(resetn),
        .osc_in(osc_in),
        .clk_sel(clk_s2_reg[IADC_RATE_LSB +: 2]),
        .tick(tick)
    );

    // Negative-polarity conversions see an inverted stream from the swapped front end
    iadc_integrator #(.ACC_W(ACC_W)) u_int (
        .clock(clock),
        .resetn(resetn),
        .clear(harvest_reg || state_reg == IADC_INIT),
        .sample(state_reg == IADC_ELEM && tick),
        .bit_in(modulator_bit ^ chop_reg), // RQ5
        .acc(acc)
    );

    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
        wr_en = bus_req && wb_we_i && wb_sel_i[0];
        start_wr = wr_en && wb_adr_i == IADC_ADR_SETUP_A
            && (wb_dat_i[IADC_START_BIT] || wb_dat_i[IADC_ALT_START_BIT]); // RQ1
        osr_val = 11'(11'h001 << (IADC_OSR_EXP_BASE + 5'(cfg_reg.osr_sel))); // RQ9
        last_elem = 3'(4'h1 << cfg_reg.nelc_sel) - 3'h1; // RQ10
        elem_end = state_reg == IADC_ELEM && tick && tick_cnt_reg == osr_val; // RQ3
    end

    // Register file and bus answer
    always_comb begin
        ack_next = bus_req;
        rdat_next = 32'h0000_0000;
        setup_a_next = setup_a_reg;
        enable_next = enable_reg;
        clk_s2_next = clk_s2_reg;
        s3_gain_next = s3_gain_reg;
        s3_off_next = s3_off_reg;
        bg_next = bg_reg;
        done_next = done_reg;
        if (state_reg == IADC_FINAL && tick) begin
            setup_a_next[IADC_ALT_START_BIT:IADC_START_BIT] = 2'h0; // RQ19
            done_next = 1'b1; // RQ19
        end
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                IADC_ADR_SETUP_A: rdat_next[7:0] = setup_a_reg;
                IADC_ADR_ENABLE: rdat_next[3:0] = enable_reg;
                IADC_ADR_CLK_STAGE2: rdat_next[7:0] = clk_s2_reg;
                IADC_ADR_STAGE3_GAIN: rdat_next[7:0] = s3_gain_reg;
                IADC_ADR_STAGE3_OFFSET: rdat_next[6:0] = s3_off_reg;
                IADC_ADR_BANDGAP: rdat_next[1:0] = bg_reg;
                IADC_ADR_RESULT: rdat_next[15:0] = result_reg; // RQ17
                IADC_ADR_STATUS: begin
                    rdat_next[IADC_DONE_BIT] = done_reg;
                    rdat_next[IADC_BUSY_BIT] = state_reg != IADC_IDLE;
                    rdat_next[IADC_RES_LSB +: 5] = iadc_res_bits(
                        setup_a_reg[IADC_OSR_LSB +: 3], setup_a_reg[IADC_NELC_LSB +: 2]); // RQ12
                end
                default: rdat_next = 32'h0000_0000;
            endcase
        end
        if (wr_en) begin
            case (wb_adr_i)
                IADC_ADR_SETUP_A: setup_a_next = wb_dat_i[7:0]; // RQ1
                IADC_ADR_ENABLE: enable_next = wb_dat_i[3:0]; // RQ16
                IADC_ADR_CLK_STAGE2: clk_s2_next = wb_dat_i[7:0]; // RQ14
                IADC_ADR_STAGE3_GAIN: s3_gain_next = wb_dat_i[7:0]; // RQ13
                IADC_ADR_STAGE3_OFFSET: s3_off_next = wb_dat_i[6:0]; // RQ15
                IADC_ADR_BANDGAP: bg_next = wb_dat_i[1:0]; // RQ7
                // Completion in the same cycle keeps done set
                IADC_ADR_STATUS: begin
                    if (wb_dat_i[IADC_DONE_BIT] && !(state_reg == IADC_FINAL && tick)) begin
                        done_next = 1'b0;
                    end
                end
                default: done_next = done_next;
            endcase
        end
        if (start_wr) begin
            done_next = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            setup_a_reg <= IADC_SETUP_A_RST;
            enable_reg <= IADC_ENABLE_RST;
            clk_s2_reg <= IADC_CLK_STAGE2_RST;
            s3_gain_reg <= IADC_BYTE_RST;
            s3_off_reg <= 7'h00;
            bg_reg <= IADC_BG_LOW;
            done_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            setup_a_reg <= setup_a_next;
            enable_reg <= enable_next;
            clk_s2_reg <= clk_s2_next;
            s3_gain_reg <= s3_gain_next;
            s3_off_reg <= s3_off_next;
            bg_reg <= bg_next;
            done_reg <= done_next;
        end
    end

    // Conversion sequence
    always_comb begin
        state_next = state_reg;
        cfg_next = cfg_reg;
        tick_cnt_next = tick_cnt_reg;
        elem_cnt_next = elem_cnt_reg;
        sum_next = sum_reg;
        harvest_next = 1'b0;
        chop_next = chop_reg;
        bgs_next = bgs_reg;
        integ_next = 1'b0;
        result_next = result_reg;
        if (harvest_reg) begin
            sum_next = sum_reg + SUM_W'(acc); // RQ4
        end
        case (state_reg)
            IADC_IDLE: begin
                chop_next = 1'b0;
            end
            IADC_INIT: begin
                // One tick of settling aligns the first conversion to the period
                if (tick) begin
                    state_next = IADC_ELEM; // RQ6
                    tick_cnt_next = 11'h000;
                    elem_cnt_next = 3'h0;
                    sum_next = '0;
                    chop_next = 1'b0;
                    bgs_next = cfg_reg.bg_mode == IADC_BG_HIGH; // RQ7
                end
            end
            IADC_ELEM: begin
                integ_next = 1'b1;
                if (elem_end) begin
                    harvest_next = 1'b1;
                    tick_cnt_next = 11'h000;
                    chop_next = !chop_reg; // RQ5
                    if (cfg_reg.bg_mode == IADC_BG_TOGGLE
                        || (cfg_reg.bg_mode == IADC_BG_HALF && elem_cnt_reg[0])) begin
                        bgs_next = !bgs_reg; // RQ7
                    end
                    if (elem_cnt_reg == last_elem) begin
                        state_next = IADC_FINAL; // RQ2
                        integ_next = 1'b0;
                    end else begin
                        elem_cnt_next = elem_cnt_reg + 3'h1; // RQ2
                    end
                end else if (tick) begin
                    tick_cnt_next = tick_cnt_reg + 11'h001; // RQ3
                end
            end
            IADC_FINAL: begin
                // One closing period for the final quantization
                if (tick) begin
                    state_next = IADC_IDLE; // RQ18
                    result_next = iadc_align(sum_reg,
                        iadc_res_bits(cfg_reg.osr_sel, cfg_reg.nelc_sel)); // RQ4
                end
            end
            default: state_next = IADC_IDLE;
        endcase
        if (start_wr) begin
            state_next = IADC_INIT; // RQ20
            integ_next = 1'b0;
            cfg_next.osr_sel = wb_dat_i[IADC_OSR_LSB +: 3]; // RQ9
            cfg_next.nelc_sel = wb_dat_i[IADC_NELC_LSB +: 2]; // RQ10
            cfg_next.bg_mode = bg_reg;
            bgs_next = bg_reg == IADC_BG_HIGH;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= IADC_IDLE;
            cfg_reg <= '0;
            tick_cnt_reg <= 11'h000;
            elem_cnt_reg <= 3'h0;
            sum_reg <= '0;
            harvest_reg <= 1'b0;
            chop_reg <= 1'b0;
            bgs_reg <= 1'b0;
            integ_reg <= 1'b0;
            result_reg <= IADC_RESULT_RST;
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            tick_cnt_reg <= tick_cnt_next;
            elem_cnt_reg <= elem_cnt_next;
            sum_reg <= sum_next;
            harvest_reg <= harvest_next;
            chop_reg <= chop_next;
            bgs_reg <= bgs_next;
            integ_reg <= integ_next;
            result_reg <= result_next;
        end
    end

    assign wb_dat_o = rdat_reg;
    assign wb_ack_o = ack_reg;
    assign chop_polarity = chop_reg;
    assign bandgap_state = bgs_reg;
    assign integrate_active = integ_reg;
    assign stage_enable = enable_reg; // RQ16
    assign stage1_gain_select = s3_gain_reg[IADC_S1_GAIN_BIT]; // RQ13
    assign stage2_gain_select = clk_s2_reg[IADC_S2_GAIN_LSB +: 2]; // RQ14
    assign stage2_offset_select = clk_s2_reg[3:0]; // RQ14
    assign stage3_gain_select = s3_gain_reg[6:0]; // RQ15
    assign stage3_offset_select = s3_off_reg; // RQ15

    // Ticks counted from the first conversion period to completion
    logic [13:0] conv_ticks;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            conv_ticks <= 14'h0000;
        end else if (state_reg == IADC_INIT) begin
            conv_ticks <= 14'h0000;
        end else if (tick && state_reg != IADC_IDLE) begin
            conv_ticks <= conv_ticks + 14'h0001;
        end
    end

    property p_start;
        @(posedge clock) disable iff (!resetn)
        start_wr |=> state_reg == IADC_INIT;
    endproperty
    a_start: assert property (p_start) else $error("start ignored"); // RQ1

    property p_restart;
        @(posedge clock) disable iff (!resetn)
        (start_wr && state_reg == IADC_ELEM) |=> state_reg == IADC_INIT ##1 elem_cnt_reg == 3'h0 || state_reg == IADC_INIT;
    endproperty
    a_restart: assert property (p_restart) else $error("restart failed"); // RQ20

    property p_elem_len;
        @(posedge clock) disable iff (!resetn)
        (state_reg == IADC_ELEM && tick && !start_wr) |-> tick_cnt_reg <= osr_val;
    endproperty
    a_elem_len: assert property (p_elem_len) else $error("elementary length wrong"); // RQ3

    property p_elem_count;
        @(posedge clock) disable iff (!resetn)
        (state_reg == IADC_ELEM && !start_wr ##1 state_reg == IADC_FINAL)
            |-> $past(elem_cnt_reg) == last_elem;
    endproperty
    a_elem_count: assert property (p_elem_count) else $error("wrong count"); // RQ2

    property p_chop;
        @(posedge clock) disable iff (!resetn)
        (elem_end && !start_wr) |=> chop_reg != $past(chop_reg);
    endproperty
    a_chop: assert property (p_chop) else $error("polarity not reversed"); // RQ5

    property p_bg_fixed;
        @(posedge clock) disable iff (!resetn)
        (state_reg == IADC_ELEM && cfg_reg.bg_mode == IADC_BG_HIGH) |-> bgs_reg;
    endproperty
    a_bg_fixed: assert property (p_bg_fixed) else $error("bandgap not held"); // RQ7

    property p_done;
        @(posedge clock) disable iff (!resetn)
        (state_reg == IADC_FINAL && tick && !start_wr)
            |=> done_reg && state_reg == IADC_IDLE && setup_a_reg[1:0] == 2'h0;
    endproperty
    a_done: assert property (p_done) else $error("completion incomplete"); // RQ19

    property p_total;
        @(posedge clock) disable iff (!resetn)
        (state_reg == IADC_FINAL && tick && !start_wr)
            |-> conv_ticks == 14'((4'h1 << cfg_reg.nelc_sel) * (osr_val + 11'h001));
    endproperty
    a_total: assert property (p_total) else $error("conversion time wrong"); // RQ18
endmodule : iadc_sequencer
`default_nettype wire

// ===== iadc_analog_model.sv
// Analog-side model: free oscillator and railed modulator
`timescale 1ns/1ns
`default_nettype none
module iadc_analog_model (
    // Oscillator
    output logic osc,
    // Modulator
    input wire logic level,
    output logic mod_bit
);
    // Offset keeps oscillator edges off the bench clock edges
    initial begin
        osc = 1'b0;
        #7;
        forever #125 osc = ~osc;
    end
    // A railed input is the worst case for offset
    assign mod_bit = level;
endmodule : iadc_analog_model
`default_nettype wire

// ===== test_iadc_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module test_iadc_sequencer;
    import iadc_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic level = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o, rd;
    logic ack, osc, mb, chop, bg, integ, s1;
    logic [3:0] en, s2o;
    logic [1:0] s2g;
    logic [6:0] s3g, s3o;
    logic [15:0] res, res_a;
    logic [7:0] wa [5] = '{IADC_ADR_ENABLE, IADC_ADR_CLK_STAGE2, IADC_ADR_STAGE3_GAIN,
        IADC_ADR_STAGE3_OFFSET, IADC_ADR_BANDGAP};
    logic [7:0] wd [5] = '{8'h0D, 8'hE7, 8'hD5, 8'h2A, 8'h03};
    int err_total = 0;
    int checks = 0;
    int cyc_n = 0;
    iadc_sequencer DUT (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .osc_in(osc), .modulator_bit(mb), .chop_polarity(chop),
        .bandgap_state(bg), .integrate_active(integ), .stage_enable(en),
        .stage1_gain_select(s1), .stage2_gain_select(s2g),
        .stage2_offset_select(s2o), .stage3_gain_select(s3g),
        .stage3_offset_select(s3o));
    iadc_analog_model model (.osc(osc), .level(level), .mod_bit(mb));
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            err_total = err_total + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // Stb rides on cyc: classic single cycles only
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        rd = dat_o;
        cyc <= 1'b0;
        @(posedge clock);
    endtask : wb
    task automatic run(input logic [7:0] cfg, input int p, input logic [1:0] bgm);
        int n, osr, w;
        logic e;
        osr = 8 << cfg[4:2];
        n = 1 << cfg[6:5];
        wb(1'b1, IADC_ADR_BANDGAP, {30'h0, bgm});
        wb(1'b1, IADC_ADR_SETUP_A, {24'h0, cfg});
        repeat (2) @(posedge clock);
        w = 0;
        while (integ !== 1'b1 && w < 2 * p + 9) begin
            @(posedge clock);
            w++;
        end
        chk("init", 1, w < 2 * p + 9);
        for (int k = 0; k < n; k++) begin
            repeat ((osr + 1) * p / 2) @(posedge clock);
            e = (bgm == 2'h1) || (bgm == 2'h2 && k[0]) || (bgm == 2'h3 && k[1]);
            chk("chop", k[0], chop);
            chk("bandgap", e, bg);
            repeat ((osr + 1) * p - (osr + 1) * p / 2 - 4) @(posedge clock);
            chk("active", 1, integ);
            repeat (4) @(posedge clock);
        end
        repeat (2) @(posedge clock);
        chk("ended", 0, integ);
        w = 0;
        rd = 0;
        while (rd[IADC_DONE_BIT] !== 1'b1 && w < 400) begin
            wb(1'b0, IADC_ADR_STATUS, 0);
            w++;
        end
        chk("final", 1, 3 * w > p / 2 && 3 * w < p + 12);
        wb(1'b0, IADC_ADR_RESULT, 0);
        res = rd[15:0];
        wb(1'b0, IADC_ADR_SETUP_A, 0);
        chk("start bits", {24'h0, cfg & 8'hFC}, rd);
        wb(1'b1, IADC_ADR_STATUS, 1);
        wb(1'b0, IADC_ADR_STATUS, 0);
        chk("done", 0, rd[IADC_DONE_BIT]);
    endtask : run
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        chk("outputs", 0, {chop, bg, integ, en, s1, s2g, s2o, s3g, s3o});
        for (int a = 0; a < 9; a++) begin
            wb(1'b0, 8'(a * 4), 0);
            chk("reset", (a == 7) ? 32'h600 : 0, rd);
        end
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, wa[i], {24'h0, wd[i]});
            wb(1'b0, wa[i], 0);
            chk("readback", {24'h0, wd[i]}, rd);
        end
        chk("stages", 25'h1B9_EAAA, {en, s1, s2g, s2o, s3g, s3o});
        sel <= 4'hE;
        wb(1'b1, IADC_ADR_STAGE3_OFFSET, 32'h11);
        sel <= 4'hF;
        wb(1'b1, IADC_ADR_RESULT, 32'hFFFF);
        wb(1'b1, 8'h20, 32'hFF);
        wb(1'b0, IADC_ADR_STAGE3_OFFSET, 0);
        chk("lanes", 32'h2A, rd);
        wb(1'b0, IADC_ADR_RESULT, 0);
        chk("result", 0, rd);
        wb(1'b1, IADC_ADR_SETUP_A, 32'h28);
        wb(1'b0, IADC_ADR_STATUS, 0);
        chk("resolution", 11, rd[12:8]);
        run(8'h41, 50, 2'h2);
        res_a = res;
        chk("mean", 32'h5A00, res);
        level <= 1'b1;
        // Eight conversions average to the same code as four
        run(8'h61, 50, 2'h3);
        chk("offset", res_a, res);
        run(8'h01, 50, 2'h1);
        chk("single", 32'hB400, res);
        level <= 1'b0;
        // Every rate, slowest first
        for (int f = 0; f < 4; f++) begin
            wb(1'b1, IADC_ADR_CLK_STAGE2, {24'h0, 2'(f), 6'h27});
            run({3'h0, 3'(f), 2'h1}, 400 >> f, 2'(f));
        end
        chk("zero", 0, res);
        wb(1'b1, IADC_ADR_SETUP_A, 32'h23);
        repeat (200) @(posedge clock);
        run(8'h22, 50, 2'h0);
        chk("restart", 32'h5A00, res);
        close_out();
    end
endmodule : test_iadc_sequencer
`default_nettype wire
